// >>> cms_device.sv
/*
 * Device end: waits out the settling time, latches the connector mode
 * once, gates chip selects and ATA reset, drives DMA/ready/card detect.
 * Assumes reset_i is power-on only; connector reset is a link input.
 */
`timescale 1ns/1ps
`default_nettype none
module cms_device
	import cms_pkg::*;
#(
	parameter int SETTLE_CYC = CMS_SETTLE_CYC,
	parameter bit USE_CSEL = CMS_USE_CSEL,
	parameter bit CS1_PIN_B = 1'b0,
	parameter bit HAS_DMA = 1'b1,
	parameter bit HAS_IORDY = 1'b1
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	cms_if.dev link,
	input wire logic dmarq_i,
	input wire logic iordy_i,
	output logic [1:0] mode_o,
	output logic ata_active_o,
	output logic ata_reset_o,
	output logic cs0_o,
	output logic cs1_o,
	output logic dev1_o,
	output logic dmack_o,
	output logic rd_o,
	output logic wr_o,
	output logic [2:0] addr_o
);
	cms_mode_t mode;
	cms_mode_t next_mode;
	logic settled;
	logic mode_locked;

	cms_settle #(.SETTLE_CYC(SETTLE_CYC)) u_settle (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.done_o(settled)
	);

	wire act = (mode == CMS_ATA68);
	wire settling = (mode == CMS_SETTLING);
	// Missing pulls on an unpowered slot leave it floating; only a clean high reads as negated, anything else as asserted
	wire sel_asserted = (link.selata_n !== CMS_NEGATED_LOW);
	wire cs1_pin = CS1_PIN_B ? link.cs1_b_n : link.cs1_a_n;
	wire devnum = USE_CSEL ? link.csel : !link.ms_n;
	// Active-low reset here: an alternate-mode host drives it high, holding us
	wire rst_hold = !act || !link.reset_n;

	// Only 68-pin mode pins feed the decode; the alternate-only address
	// and write-enable pins have no path in at all
	wire next_cs0 = act && !link.cs0_n;
	wire next_cs1 = act && !cs1_pin;
	wire next_dev1 = act && devnum;
	wire next_dmack = act && HAS_DMA && !link.dmack_n;
	wire next_rd = act && !link.dior_n;
	wire next_wr = act && !link.diow_n;
	wire [2:0] next_addr = act ? link.da : 3'h0;
	wire next_dmarq = act && HAS_DMA && dmarq_i;
	wire next_iordy = !act || !HAS_IORDY || iordy_i;

	always_comb begin
		next_mode = mode;
		case (mode)
			CMS_SETTLING: begin
				if (settled && !mode_locked) begin
					next_mode = sel_asserted ? CMS_ATA68 : CMS_ALT;
				end
			end
			CMS_ATA68: begin
				if (!sel_asserted) begin
					next_mode = CMS_DISABLED;
				end
			end
			CMS_ALT: next_mode = CMS_ALT;
			CMS_DISABLED: next_mode = CMS_DISABLED;
			default: next_mode = CMS_DISABLED;
		endcase
	end

	// Sticky: only power-on reset clears it, never the link reset
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			mode_locked <= 1'b0;
		end else if (settling && settled) begin
			mode_locked <= 1'b1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			mode <= CMS_SETTLING;
		end else begin
			mode <= next_mode;
		end
	end

	// Every output but the card detects is registered, so nothing decodes before settling ends
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			mode_o <= 2'h0;
		end else begin
			mode_o <= 2'(mode);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			ata_active_o <= 1'b0;
		end else begin
			ata_active_o <= act;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			ata_reset_o <= 1'b1;
		end else begin
			ata_reset_o <= rst_hold;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			cs0_o <= 1'b0;
		end else begin
			cs0_o <= next_cs0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			cs1_o <= 1'b0;
		end else begin
			cs1_o <= next_cs1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			dev1_o <= 1'b0;
		end else begin
			dev1_o <= next_dev1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			dmack_o <= 1'b0;
		end else begin
			dmack_o <= next_dmack;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			rd_o <= 1'b0;
		end else begin
			rd_o <= next_rd;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			wr_o <= 1'b0;
		end else begin
			wr_o <= next_wr;
		end
	end

	for (genvar g = 0; g < $bits(addr_o); g++) begin : g_addr
		always_ff @(posedge core_clk_i) begin
			if (reset_i) begin
				addr_o[g] <= 1'b0;
			end else begin
				addr_o[g] <= next_addr[g];
			end
		end
	end

	// Held quiet until the mode is known, so a settling device never asks
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			link.dmarq <= 1'b0;
		end else begin
			link.dmarq <= next_dmarq;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			link.iordy <= 1'b1;
		end else begin
			link.iordy <= next_iordy;
		end
	end

	// Grounded even while held, so the host sees us from power-up
	assign link.cd1_n = 1'b0;
	assign link.cd2_n = 1'b0;
endmodule : cms_device
`default_nettype wire

// >>> cms_pkg.sv
/*
 * Constants for the 68-pin connector mode-select block: settling time,
 * device-number select choices, mode encoding.
 * Assumes a single 40 MHz core clock on both ends.
 */
package cms_pkg;
	localparam int CMS_CLK_HZ = 40000000;
	localparam int CMS_SETTLE_MS = 19;
	localparam int CMS_SETTLE_CYC = CMS_CLK_HZ / 1000 * CMS_SETTLE_MS;
	localparam int CMS_CNT_W = 20;
	localparam logic CMS_NEGATED_LOW = 1'h1;
	localparam logic CMS_USE_CSEL = 1'h1;
	localparam logic CMS_CS1_PIN_A = 1'h0;
	typedef enum logic [1:0] {
		CMS_SETTLING,
		CMS_ATA68,
		CMS_ALT,
		CMS_DISABLED
	} cms_mode_t;
endpackage : cms_pkg

// >>> cms_if.sv
/*
 * Connector wires between host and device ends. Active-low pins carry
 * the _n suffix. Assumes the testbench ties card detects to the device.
 */
`timescale 1ns/1ps
`default_nettype none
interface cms_if;
	logic selata_n;
	logic reset_n;
	logic cs0_n;
	logic cs1_a_n;
	logic cs1_b_n;
	logic csel;
	logic ms_n;
	logic dior_n;
	logic diow_n;
	logic [2:0] da;
	logic dmack_n;
	logic dmarq;
	logic iordy;
	logic cd1_n;
	logic cd2_n;
	logic [7:0] alt_addr;
	logic alt_we_n;
	modport host (
		output selata_n, reset_n, cs0_n, cs1_a_n, cs1_b_n, csel, ms_n,
		output dior_n, diow_n, da, dmack_n, alt_addr, alt_we_n,
		input dmarq, iordy, cd1_n, cd2_n
	);
	modport dev (
		input selata_n, reset_n, cs0_n, cs1_a_n, cs1_b_n, csel, ms_n,
		input dior_n, diow_n, da, dmack_n, alt_addr, alt_we_n,
		output dmarq, iordy, cd1_n, cd2_n
	);
endinterface : cms_if
`default_nettype wire

// >>> cms_settle.sv
/*
 * Settling counter: raises done after the power-on count elapses and holds it high.
 * Assumes reset_i is the power-on reset only.
 */
`timescale 1ns/1ps
`default_nettype none
module cms_settle
	import cms_pkg::*;
#(
	parameter int SETTLE_CYC = CMS_SETTLE_CYC
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	output logic done_o
);
	logic [CMS_CNT_W-1:0] count;
	wire at_end = (count == CMS_CNT_W'(SETTLE_CYC - 1));
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			count <= '0;
			done_o <= 1'b0;
		end else if (!done_o) begin
			count <= count + 1'b1;
			done_o <= at_end;
		end
	end
endmodule : cms_settle
`default_nettype wire

// >>> cms_host.sv
/*
 * Host end: drives select, CSEL and M/S before granting power, both
 * CS1 positions alike, senses presence and resets on insertion change.
 * Assumes the power switch follows power_on_o.
 */
`timescale 1ns/1ps
`default_nettype none
module cms_host
	import cms_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic reset_i,
	cms_if.host link,
	input wire logic power_req_i,
	input wire logic dev1_i,
	input wire logic cs0_i,
	input wire logic cs1_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [2:0] addr_i,
	input wire logic dmack_i,
	input wire logic ata_reset_i,
	output logic power_on_o,
	output logic present_o,
	output logic change_o,
	output logic dmarq_o,
	output logic iordy_o
);
	logic present;
	wire det = !link.cd1_n && !link.cd2_n;
	wire changed = det != present;
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			present <= 1'b0;
			present_o <= 1'b0;
			change_o <= 1'b0;
			power_on_o <= 1'b0;
			dmarq_o <= 1'b0;
			iordy_o <= 1'b0;
		end else begin
			present <= det;
			present_o <= det;
			change_o <= changed;
			power_on_o <= power_req_i && det;
			dmarq_o <= link.dmarq;
			iordy_o <= link.iordy;
		end
	end
	// Levels are driven from reset, so they precede any power grant
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			link.selata_n <= 1'b0;
			link.reset_n <= 1'b0;
			link.cs0_n <= 1'b1;
			link.cs1_a_n <= 1'b1;
			link.cs1_b_n <= 1'b1;
			link.csel <= 1'b0;
			link.ms_n <= 1'b1;
			link.dior_n <= 1'b1;
			link.diow_n <= 1'b1;
			link.da <= 3'h0;
			link.dmack_n <= 1'b1;
		end else begin
			link.selata_n <= 1'b0;
			link.reset_n <= !(ata_reset_i || changed);
			link.cs0_n <= !cs0_i;
			link.cs1_a_n <= !cs1_i;
			link.cs1_b_n <= !cs1_i;
			link.csel <= dev1_i;
			link.ms_n <= !dev1_i;
			link.dior_n <= !rd_i;
			link.diow_n <= !wr_i;
			link.da <= addr_i;
			link.dmack_n <= !dmack_i;
		end
	end
	assign link.alt_addr = 8'h00;
	assign link.alt_we_n = 1'b1;
endmodule : cms_host
`default_nettype wire

// >>> cms_properties.sv
/* Checker on the host-device connector wires.
   Assumes one core clock and a synchronous active-high power-on reset. */
`timescale 1ns/1ps
`default_nettype none
module cms_properties
	import cms_pkg::*;
#(
	parameter int SETTLE_CYC = CMS_SETTLE_CYC
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic selata_n,
	input wire logic reset_n,
	input wire logic cs1_a_n,
	input wire logic cs1_b_n,
	input wire logic csel,
	input wire logic ms_n,
	input wire logic dmarq,
	input wire logic iordy,
	input wire logic cd1_n,
	input wire logic cd2_n
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	// Saturates so it never wraps during long runs
	int age;
	always_ff @(posedge core_clk_i) begin
		age <= reset_i ? 0 : (age < SETTLE_CYC + 4 ? age + 1 : age);
	end
	a_card_detect_low: assert property (cd1_n == 1'h0 && cd2_n == 1'h0)
		else $error("card detect not grounded");
	a_cs1_pins_alike: assert property (cs1_a_n == cs1_b_n)
		else $error("chip select 1 positions differ");
	a_msel_inverse: assert property (ms_n == !csel)
		else $error("master select not inverse of cable select");
	a_msel_pair_move: assert property ($changed(csel) |-> $changed(ms_n))
		else $error("select pair moved apart");
	a_select_held: assert property (selata_n == 1'h0)
		else $error("mode select not asserted");
	a_select_from_start: assert property ($fell(reset_i) |-> !selata_n [*8])
		else $error("mode select dropped after power");
	a_quiet_settling: assert property (age < SETTLE_CYC |-> dmarq == 1'h0 && iordy == 1'h1)
		else $error("device drove lines while settling");
	a_reset_after_por: assert property ($fell(reset_i) |-> reset_n == 1'h0)
		else $error("link reset not held at power-up");
	cover property (age == SETTLE_CYC + 2);
	cover property ($rose(dmarq));
	cover property ($fell(iordy));
endmodule : cms_properties
`default_nettype wire

// >>> cms_bench.sv
/* Bench joining host and device ends through one link.
   Assumes a shortened settling count; inputs change on falling edges. */
`timescale 1ns/1ps
`default_nettype none
module cms_bench
	import cms_pkg::*;
;
	localparam int SETTLE = 20;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic pwr, dev1, cs0, cs1, rd, wr, ack, arst, dq_i, rdy_i;
	logic [2:0] addr;
	logic power_on, present, change, h_dmarq, h_iordy;
	logic [1:0] mode;
	logic act, d_arst, d_cs0, d_cs1, d_dev1, d_ack, d_rd, d_wr;
	logic [2:0] d_addr;
	int err_count = 0;
	int comparisons = 0;
	int cycles = 0;
	cms_if lnk();
	cms_host i_cms_host (.core_clk_i(clk), .reset_i(rst), .link(lnk), .power_req_i(pwr),
		.dev1_i(dev1), .cs0_i(cs0), .cs1_i(cs1), .rd_i(rd), .wr_i(wr), .addr_i(addr),
		.dmack_i(ack), .ata_reset_i(arst), .power_on_o(power_on), .present_o(present),
		.change_o(change), .dmarq_o(h_dmarq), .iordy_o(h_iordy));
	cms_device #(.SETTLE_CYC(SETTLE)) i_cms_device (.core_clk_i(clk), .reset_i(rst),
		.link(lnk), .dmarq_i(dq_i), .iordy_i(rdy_i), .mode_o(mode), .ata_active_o(act),
		.ata_reset_o(d_arst), .cs0_o(d_cs0), .cs1_o(d_cs1), .dev1_o(d_dev1),
		.dmack_o(d_ack), .rd_o(d_rd), .wr_o(d_wr), .addr_o(d_addr));
	cms_properties #(.SETTLE_CYC(SETTLE)) i_cms_properties (.core_clk_i(clk), .reset_i(rst),
		.selata_n(lnk.selata_n), .reset_n(lnk.reset_n), .cs1_a_n(lnk.cs1_a_n),
		.cs1_b_n(lnk.cs1_b_n), .csel(lnk.csel), .ms_n(lnk.ms_n), .dmarq(lnk.dmarq),
		.iordy(lnk.iordy), .cd1_n(lnk.cd1_n), .cd2_n(lnk.cd2_n));
	always #12.5 clk = ~clk;
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk
	task automatic settle4();
		repeat (4) @(negedge clk);
	endtask : settle4
	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize
	// Ceiling is over forty times the expected run
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			err_count++;
			summarize();
		end
	end
	initial begin
		{pwr, dev1, cs0, cs1, rd, wr, ack, arst, dq_i} = '0;
		rdy_i = 1'b1;
		addr = 3'h0;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		pwr = 1'b1;
		cs0 = 1'b1;
		@(negedge clk);
		chk(8'(change), 8'h01);
		settle4();
		chk(8'(change), 8'h00);
		chk(8'(power_on), 8'h01);
		chk(8'(mode), 8'h00);
		chk(8'(d_cs0), 8'h00);
		chk(8'(present), 8'h01);
		$display("test settling done");
		repeat (SETTLE) @(negedge clk);
		chk(8'(mode), 8'h01);
		chk(8'(act), 8'h01);
		{dev1, cs1, rd, dq_i, ack} = 5'h1F;
		addr = 3'h5;
		rdy_i = 1'b0;
		settle4();
		chk(8'({d_cs0, d_cs1}), 8'h03);
		chk(8'(d_dev1), 8'h01);
		chk(8'({d_rd, d_wr, d_addr}), 8'h15);
		chk(8'({h_dmarq, d_ack}), 8'h03);
		chk(8'(h_iordy), 8'h00);
		rd = 1'b0;
		wr = 1'b1;
		settle4();
		chk(8'({d_rd, d_wr}), 8'h01);
		$display("test access done");
		arst = 1'b1;
		settle4();
		chk(8'({mode, d_arst}), 8'h03);
		arst = 1'b0;
		settle4();
		chk(8'({mode, d_arst}), 8'h02);
		$display("test link reset done");
		summarize();
	end
endmodule : cms_bench
`default_nettype wire
